// file: dswk_wake_status.sv
// deep-sleep wake flags, retained byte and rc discharge wake circuit
//
// Overview of operation
// - retained byte survives deep sleep unchanged
// - retained byte lost only on supply loss
// - pin-change during deep sleep sets high bit0
// - sleep fault sets low bit 7
// - sleep watchdog timeout sets low bit 4
// - calendar alarm in deep sleep sets bit3
// - reset pin in deep sleep sets bit2
// - power-on event sets bit0, resets to one
// - low bits 6 and 1 read zero
// - rc wake from sleep sets level flag
// - rc wake from deep sleep sets bit5
// - pin below threshold interrupts and wakes
// - only wake output drives detect in sleep
// - deep-sleep wake runs full reset sequence
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "dswk_cfg.svh"
module dswk_wake_status
    import dswk_pkg::*;
(
    // clock and reset (rstn is the always-on power-on reset)
    input wire logic clock,
    input wire logic rstn,
    // apb register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power state from the sleep controller
    input wire logic sleep_entered,
    input wire logic deep_sleep_entered,
    input wire logic wake_done,
    // supply monitors that corrupt the retained byte
    input wire logic core_brownout,
    input wire logic sleep_brownout_detector,
    input wire logic supply_hard_cycle,
    // wake sources
    input wire logic external_interrupt_input,
    input wire logic sleep_fault_event,
    input wire logic sleep_watchdog_timeout,
    input wire logic calendar_alarm,
    input wire logic master_reset_pin,
    input wire logic power_on_detect,
    // rc wake pin
    input wire logic rc_wake_pin_in,
    output logic rc_wake_pin_out,
    output logic rc_wake_pin_oe,
    // wake results
    output logic rc_wake_output_signal,
    output logic wake_request,
    output logic deep_wake_reset_req,
    output logic irq
);
    import dswk_pkg::*;

    logic wr_stb;
    logic rd_stb;
    logic [9:0] word_idx;
    logic [7:0] wake_low;
    logic [7:0] wake_high;
    logic [7:0] retained;
    logic [7:0] wdt_ctrl;
    logic [`DSWK_IRQ_WIDTH-1:0] irq_status;
    logic [`DSWK_IRQ_WIDTH-1:0] irq_mask;
    logic [`DSWK_IRQ_WIDTH-1:0] irq_event;
    logic below_threshold;
    logic fall_pulse;
    logic rc_armed;
    logic in_deep;
    logic in_sleep;
    logic [7:0] wdata;
    logic [7:0] next_rdata;
    dswk_power_t power;

    // word index match against a register index, shared by every decode
    function automatic logic hit(input logic [9:0] idx, input logic [11:0] reg_idx);
        hit = (idx == reg_idx[9:0]);
    endfunction : hit

    // state decodes and the arm condition of the discharge sink
    assign wdata = pwdata[7:0];
    assign in_deep = (power == dswk_deep_sleep);
    assign in_sleep = (power == dswk_sleep);
    assign rc_armed = wdt_ctrl[`DSWK_WDT_ENABLE] && wdt_ctrl[`DSWK_WDT_SINK];

    ////////////////////////////////////////////////////////////////////////////
    // bus front end; one wait state lets read data come from a flop
    dswk_apb_slave u_apb (
        .clock(clock),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .word_idx(word_idx)
    );

    // low-level qualifier on the wake pin, only counts while armed
    dswk_rc_detect u_rc (
        .clock(clock),
        .rstn(rstn),
        .armed(rc_armed),
        .pin_level(rc_wake_pin_in),
        .below_threshold(below_threshold),
        .fall_pulse(fall_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // power state tracking; deep-sleep wakes go through a full reset
    always_ff @(posedge clock) begin
        if (!rstn) begin
            power <= dswk_run;
        end else begin
            case (power)
                dswk_run: begin
                    if (deep_sleep_entered) begin
                        power <= dswk_deep_sleep;
                    end else if (sleep_entered) begin
                        power <= dswk_sleep;
                    end
                end
                dswk_sleep: begin
                    if (fall_pulse || external_interrupt_input) begin
                        power <= dswk_run;
                    end
                end
                dswk_deep_sleep: begin
                    if (fall_pulse || external_interrupt_input || sleep_fault_event
                        || sleep_watchdog_timeout || calendar_alarm || master_reset_pin) begin
                        power <= dswk_wake_reset;
                    end
                end
                default: begin
                    if (wake_done) begin
                        power <= dswk_run;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // retained byte: no reset term on purpose, only supply loss corrupts it
    always_ff @(posedge clock) begin
        if (core_brownout && !in_deep) begin
            retained <= 8'h00;
        end else if (in_deep && sleep_brownout_detector) begin
            retained <= 8'h00;
        end else if (supply_hard_cycle) begin
            retained <= 8'h00;
        end else if (wr_stb && hit(word_idx, `DSWK_IDX_RETAINED1)) begin
            retained <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake-low flags; hardware set wins over a software clear
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wake_low <= `DSWK_LOW_RESET;
        end else begin
            if (wr_stb && hit(word_idx, `DSWK_IDX_WAKE_LOW)) begin
                wake_low <= wdata & `DSWK_LOW_IMPL;
            end
            if (in_deep && sleep_fault_event) begin
                wake_low[`DSWK_LOW_FAULT] <= 1'b1;
            end
            if (in_deep && fall_pulse) begin
                wake_low[`DSWK_LOW_RCWAKE] <= 1'b1;
            end
            if (in_deep && sleep_watchdog_timeout) begin
                wake_low[`DSWK_LOW_WDT] <= 1'b1;
            end
            if (in_deep && calendar_alarm) begin
                wake_low[`DSWK_LOW_RTC] <= 1'b1;
            end
            if (in_deep && master_reset_pin) begin
                wake_low[`DSWK_LOW_MASTER_RESET_PIN] <= 1'b1;
            end
            if (power_on_detect) begin
                wake_low[`DSWK_LOW_POR] <= 1'b1;
            end
        end
    end

    // wake-high flag
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wake_high <= 8'h00;
        end else if (in_deep && external_interrupt_input) begin
            wake_high[`DSWK_HIGH_PINCHG] <= 1'b1;
        end else if (wr_stb && hit(word_idx, `DSWK_IDX_WAKE_HIGH)) begin
            wake_high <= wdata & `DSWK_HIGH_IMPL;
        end
    end

    // watchdog control: enable, sink and the sleep wake level flag
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wdt_ctrl <= 8'h00;
        end else begin
            if (wr_stb && hit(word_idx, `DSWK_IDX_WDT_CTRL)) begin
                wdt_ctrl <= wdata & `DSWK_WDT_IMPL;
            end
            if (in_sleep && fall_pulse) begin
                wdt_ctrl[`DSWK_WDT_LEVEL] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt events and write-one-to-clear status
    assign irq_event[`DSWK_IRQ_RCWAKE] = fall_pulse;
    assign irq_event[`DSWK_IRQ_PINCHG] = external_interrupt_input && (in_sleep || in_deep);
    assign irq_event[`DSWK_IRQ_DSWAKE] = (power == dswk_wake_reset) && wake_done;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_status <= '0;
        end else if (wr_stb && hit(word_idx, `DSWK_IDX_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~wdata[`DSWK_IRQ_WIDTH-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    // interrupt mask, same layout as the status word
    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_mask <= '0;
        end else if (wr_stb && hit(word_idx, `DSWK_IDX_IRQ_MASK)) begin
            irq_mask <= wdata[`DSWK_IRQ_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped reads return zero without an error
    always_comb begin
        next_rdata = 8'h00;
        if (hit(word_idx, `DSWK_IDX_WAKE_LOW)) begin
            next_rdata = wake_low & `DSWK_LOW_IMPL;
        end else if (hit(word_idx, `DSWK_IDX_WAKE_HIGH)) begin
            next_rdata = wake_high & `DSWK_HIGH_IMPL;
        end else if (hit(word_idx, `DSWK_IDX_RETAINED1)) begin
            next_rdata = retained;
        end else if (hit(word_idx, `DSWK_IDX_WDT_CTRL)) begin
            next_rdata = wdt_ctrl;
        end else if (hit(word_idx, `DSWK_IDX_IRQ_STATUS)) begin
            next_rdata = {5'h00, irq_status};
        end else if (hit(word_idx, `DSWK_IDX_IRQ_MASK)) begin
            next_rdata = {5'h00, irq_mask};
        end else if (hit(word_idx, `DSWK_IDX_POWER_STATE)) begin
            next_rdata = {6'h00, power};
        end
    end

    // read data captured in the wait state and held until the next read
    always_ff @(posedge clock) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            if (rd_stb) begin
                prdata <= {24'h00_0000, next_rdata};
            end
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin and wake outputs; the circuit only sinks, charging is software's job
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rc_wake_pin_out <= 1'b0;
            rc_wake_pin_oe <= 1'b0;
            rc_wake_output_signal <= 1'b0;
            wake_request <= 1'b0;
            deep_wake_reset_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            rc_wake_pin_out <= 1'b0;
            rc_wake_pin_oe <= rc_armed;
            rc_wake_output_signal <= rc_armed && below_threshold;
            wake_request <= (in_sleep && (fall_pulse || external_interrupt_input));
            deep_wake_reset_req <= (power == dswk_wake_reset);
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule : dswk_wake_status

// file: dswk_cfg.svh
// constants for the deep-sleep wake bookkeeping block
`ifndef DSWK_CFG_SVH
`define DSWK_CFG_SVH
// register word indices (printed offsets not all multiples of four: byte address is the low ten index bits times four)
`define DSWK_IDX_WAKE_LOW 12'hf4a
`define DSWK_IDX_WAKE_HIGH 12'hf4b
`define DSWK_IDX_RETAINED1 12'hf4f
`define DSWK_IDX_WDT_CTRL 12'hf50
`define DSWK_IDX_IRQ_STATUS 12'hf51
`define DSWK_IDX_IRQ_MASK 12'hf52
`define DSWK_IDX_POWER_STATE 12'hf53
// wake-low field positions
`define DSWK_LOW_FAULT 7
`define DSWK_LOW_RCWAKE 5
`define DSWK_LOW_WDT 4
`define DSWK_LOW_RTC 3
`define DSWK_LOW_MASTER_RESET_PIN 2
`define DSWK_LOW_POR 0
`define DSWK_LOW_IMPL 8'hbd
`define DSWK_LOW_RESET 8'h01
// wake-high field positions
`define DSWK_HIGH_PINCHG 0
`define DSWK_HIGH_IMPL 8'h01
// watchdog control fields
`define DSWK_WDT_ENABLE 0
`define DSWK_WDT_SINK 1
`define DSWK_WDT_LEVEL 5
`define DSWK_WDT_IMPL 8'h23
// interrupt status fields
`define DSWK_IRQ_RCWAKE 0
`define DSWK_IRQ_PINCHG 1
`define DSWK_IRQ_DSWAKE 2
`define DSWK_IRQ_WIDTH 3
// wake pin qualification
`define DSWK_FILTER_NS 24
`define DSWK_CLK_NS 8
`define DSWK_FILTER_CYC ((`DSWK_FILTER_NS + `DSWK_CLK_NS - 1) / `DSWK_CLK_NS)
`endif

// file: dswk_pkg.sv
// types shared by the deep-sleep wake bookkeeping block
package dswk_pkg;
    typedef enum logic [1:0] {
        dswk_run,
        dswk_sleep,
        dswk_deep_sleep,
        dswk_wake_reset
    } dswk_power_t;
endpackage : dswk_pkg

// file: dswk_rc_detect.sv
// wake pin low-level qualifier for the rc discharge circuit
`timescale 1ns/10ps
`include "dswk_cfg.svh"
module dswk_rc_detect (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // control
    input wire logic armed,
    input wire logic pin_level,
    // result
    output logic below_threshold,
    output logic fall_pulse
);
    localparam int unsigned CYC = `DSWK_FILTER_CYC;
    logic [3:0] count;

    // a low reading must persist so a glitch cannot fake a wake
    always_ff @(posedge clock) begin
        if (!rstn || !armed || pin_level) begin
            count <= 4'h0;
        end else if (count != CYC[3:0]) begin
            count <= count + 4'h1;
        end
    end

    // level and a single pulse on its first cycle
    always_ff @(posedge clock) begin
        if (!rstn) begin
            below_threshold <= 1'b0;
            fall_pulse <= 1'b0;
        end else begin
            below_threshold <= armed && (count == CYC[3:0]);
            fall_pulse <= armed && (count == CYC[3:0]) && !below_threshold;
        end
    end
endmodule : dswk_rc_detect

// file: dswk_apb_slave.sv
// apb slave front end, two-cycle access phase with one wait state
`timescale 1ns/10ps
module dswk_apb_slave (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    output logic pready,
    // decoded strobes
    output logic wr_stb,
    output logic rd_stb,
    output logic [9:0] word_idx
);
    // ready comes one cycle into the access phase; write strobe at that edge, read strobe one cycle earlier
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    assign wr_stb = psel && penable && pready && pwrite;
    assign rd_stb = psel && penable && !pready && !pwrite;
    assign word_idx = paddr[11:2];
endmodule : dswk_apb_slave

// file: dswk_wake_status_chk.sv
// port-level assertions for the deep-sleep wake bookkeeping block
`timescale 1ns/10ps
`include "dswk_cfg.svh"
module dswk_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pin and wake results
    input wire logic rc_wake_pin_in,
    input wire logic rc_wake_pin_out,
    input wire logic rc_wake_pin_oe,
    input wire logic rc_wake_output_signal,
    input wire logic wake_done,
    input wire logic deep_wake_reset_req,
    input wire logic wake_request,
    input wire logic irq
);
    localparam logic [11:0] IL = `DSWK_IDX_WAKE_LOW;
    localparam logic [11:0] IH = `DSWK_IDX_WAKE_HIGH;
    logic rd_any;
    logic rd_low;
    logic rd_high;
    // read data only means something at the edge it is taken
    assign rd_any = pready && psel && !pwrite;
    assign rd_low = rd_any && paddr == {IL[9:0], 2'b00};
    assign rd_high = rd_any && paddr == {IH[9:0], 2'b00};
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    AST_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("access phase not answered after one wait state");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    AST_NO_ERR: assert property (pready |-> !pslverr)
        else $error("slave error raised");
    AST_UPPER_ZERO: assert property (rd_any |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_HIGH_UNIMPL: assert property (rd_high |-> prdata[7:1] == 7'h0)
        else $error("wake high unused bits not zero");
    AST_LOW_UNIMPL: assert property (rd_low |-> !prdata[6] && !prdata[1])
        else $error("wake low unused bits not zero");
    AST_PIN_SINK: assert property (rc_wake_pin_oe |-> !rc_wake_pin_out)
        else $error("wake pin driven high");
    AST_RC_QUAL: assert property ($rose(rc_wake_output_signal) |->
        !$past(rc_wake_pin_in, 1) && !$past(rc_wake_pin_in, 2) && !$past(rc_wake_pin_in, 3))
        else $error("wake output without qualified low pin");
    AST_DEEP_END: assert property (deep_wake_reset_req && wake_done |-> ##[1:2] !deep_wake_reset_req)
        else $error("deep wake reset not ended by wake done");
    AST_RESET_QUIET: assert property (@(posedge clock) disable iff (1'b0)
        !rstn |=> !irq && !pready && !wake_request && !deep_wake_reset_req)
        else $error("outputs active after reset");
    // main scenarios
    COV_RD_LOW: cover property (rd_low);
    COV_WAKE: cover property ($rose(wake_request));
    COV_DEEP: cover property ($rose(deep_wake_reset_req));
    COV_IRQ: cover property ($rose(irq));
endmodule : dswk_chk

// file: dswk_rc_net.sv
// external capacitor and series resistor on the rc wake pin
`timescale 1ns/10ps
module dswk_rc_net #(
    parameter int FULL = 200,
    parameter int INPUT_LOW_THRESHOLD = 60
) (
    // clock
    input wire logic clock,
    // gpio charge from software and sink from the block
    input wire logic charge,
    input wire logic [3:0] rate,
    input wire logic sink_out,
    input wire logic sink_oe,
    // level seen by the input buffer
    output logic pin_level
);
    int v = 0;
    // no leak is modelled, so a sink that never turns on shows up as a wait_out timeout
    always @(posedge clock) begin
        if (charge) begin
            v <= FULL;
        end else if (sink_oe && !sink_out) begin
            v <= (v > rate) ? v - rate : 0;
        end
    end
    // plain threshold, no hysteresis
    assign pin_level = v > INPUT_LOW_THRESHOLD;
endmodule : dswk_rc_net

// file: dswk_wake_status_bench.sv
// self-checking bench for the deep-sleep wake bookkeeping block
`timescale 1ns/10ps
`include "dswk_cfg.svh"
module dswk_wake_status_bench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, pin_in, pin_out, pin_oe, rc_out, wake_rq, deep_rq, irq;
    logic charge = 1'b0;
    logic [3:0] rate = 4'h4;
    // 0 int 1 fault 2 wdt 3 rtc 4 master_reset_pin 5 por 6 sleep 7 deep 8 done 9..11 supply loss
    logic [11:0] drv = 12'h0;
    logic [2:0] outs;
    logic [11:0] a_low, a_high, a_ret, a_wdt, a_st, a_mk;
    int n_errors = 0;
    int n_checks = 0;
    int retm, k;
    int ret_q[$];
    int pos[5] = '{0, 7, 4, 3, 2};
    assign outs = {deep_rq, wake_rq, irq};
    ////////////////////////////////////////////////////////////////////////////////
    dswk_wake_status dut_u (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_entered(drv[6]), .deep_sleep_entered(drv[7]),
        .wake_done(drv[8]), .core_brownout(drv[9]), .sleep_brownout_detector(drv[10]),
        .supply_hard_cycle(drv[11]), .external_interrupt_input(drv[0] | rc_out),
        .sleep_fault_event(drv[1]), .sleep_watchdog_timeout(drv[2]), .calendar_alarm(drv[3]),
        .master_reset_pin(drv[4]), .power_on_detect(drv[5]), .rc_wake_pin_in(pin_in),
        .rc_wake_pin_out(pin_out), .rc_wake_pin_oe(pin_oe), .rc_wake_output_signal(rc_out),
        .wake_request(wake_rq), .deep_wake_reset_req(deep_rq), .irq(irq));
    dswk_rc_net rc_u (.clock(clock), .charge(charge), .rate(rate), .sink_out(pin_out),
        .sink_oe(pin_oe), .pin_level(pin_in));
    // clock, 8 ns period
    initial begin
        forever #4 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] ad(input logic [11:0] idx);
        return {idx[9:0], 2'b00};
    endfunction : ad
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one apb transfer; the idle cycle after it keeps psel from being set twice in a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            close_out();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h0);
        chk(nm, rd, exp);
    endtask : rdchk
    task automatic pulse(input int b, input int n);
        drv[b] <= 1'b1;
        repeat (n) @(posedge clock);
        drv[b] <= 1'b0;
        @(posedge clock);
    endtask : pulse
    task automatic wait_out(input int b);
        int i;
        for (i = 0; i < 400 && outs[b] !== 1'b1; i++) begin
            @(posedge clock);
        end
        chk("wait for output", outs[b], 1'b1);
        if (outs[b] !== 1'b1) begin
            close_out();
        end
    endtask : wait_out
    task automatic deep_exit;
        wait_out(2);
        pulse(8, 1);
    endtask : deep_exit
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(91));
        a_low = ad(`DSWK_IDX_WAKE_LOW);
        a_high = ad(`DSWK_IDX_WAKE_HIGH);
        a_ret = ad(`DSWK_IDX_RETAINED1);
        a_wdt = ad(`DSWK_IDX_WDT_CTRL);
        a_st = ad(`DSWK_IDX_IRQ_STATUS);
        a_mk = ad(`DSWK_IDX_IRQ_MASK);
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        // reset values and an unmapped place
        rdchk("wake_low", a_low, 32'h01);
        rdchk("wake_high", a_high, 32'h0);
        rdchk("irq_status", a_st, 32'h0);
        rdchk("power state", ad(`DSWK_IDX_POWER_STATE), 32'h0);
        apb(1'b1, 12'h0, 8'hff);
        rdchk("unmapped", 12'h0, 32'h0);
        $display("test reset done");
        // retained byte across deep sleep, then each loss source
        for (k = 0; k < 3; k++) begin
            retm = $urandom & 8'hff;
            ret_q.push_back(retm);
            apb(1'b1, a_ret, retm[7:0]);
            pulse(7, 1);
            pulse(0, 4);
            deep_exit();
            rdchk("retained kept", a_ret, ret_q.pop_front());
            if (k == 1) begin
                // the sleep brown-out only counts while in deep sleep
                pulse(10, 4);
                rdchk("retained in run", a_ret, retm);
                pulse(7, 1);
                pulse(10, 4);
                pulse(0, 4);
                deep_exit();
            end else begin
                pulse(9 + k, 4);
            end
            rdchk("retained lost", a_ret, 32'h0);
        end
        $display("test retained done");
        // each deep-sleep wake source but the rc pin: ignored in run, set after a deep wake, wake-low flags rechecked as sticky
        for (k = 0; k < 5; k++) begin
            apb(1'b1, a_low, 8'h0);
            apb(1'b1, a_high, 8'h0);
            pulse(k, 4);
            rdchk("run low", a_low, 32'h0);
            rdchk("run high", a_high, 32'h0);
            pulse(7, 1);
            pulse(k, 4);
            deep_exit();
            rdchk("deep low", a_low, (k == 0) ? 32'h0 : 32'h1 << pos[k]);
            rdchk("deep high", a_high, (k == 0) ? 32'h1 : 32'h0);
            repeat (5) @(posedge clock);
            rdchk("sticky low", a_low, (k == 0) ? 32'h0 : 32'h1 << pos[k]);
            apb(1'b1, a_low, 8'h0);
            apb(1'b1, a_high, 8'h0);
            rdchk("cleared low", a_low, 32'h0);
            rdchk("cleared high", a_high, 32'h0);
        end
        pulse(5, 4);
        rdchk("power on flag", a_low, 32'h01);
        $display("test wake sources done");
        // rc wake from sleep, then interrupt mask and clear
        apb(1'b1, a_st, 8'h07);
        rate <= 4'($urandom_range(8, 1));
        charge <= 1'b1;
        @(posedge clock);
        charge <= 1'b0;
        apb(1'b1, a_wdt, 8'h03);
        pulse(6, 1);
        wait_out(1);
        chk("rc output", rc_out, 1'b1);
        rdchk("wdt level", a_wdt, 32'h23);
        apb(1'b1, a_wdt, 8'h0);
        rdchk("rc status", a_st, 32'h01);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, a_mk, 8'h01);
        @(posedge clock);
        chk("irq raised", irq, 1'b1);
        apb(1'b1, a_st, 8'h01);
        @(posedge clock);
        chk("irq cleared", irq, 1'b0);
        $display("test rc sleep done");
        // rc wake from deep sleep
        apb(1'b1, a_low, 8'h0);
        charge <= 1'b1;
        @(posedge clock);
        charge <= 1'b0;
        apb(1'b1, a_wdt, 8'h03);
        pulse(7, 1);
        deep_exit();
        rdchk("deep rc flag", a_low, 32'h20);
        rdchk("deep rc status", a_st, 32'h05);
        apb(1'b1, a_wdt, 8'h0);
        $display("test rc deep done");
        close_out();
    end
endmodule : dswk_wake_status_bench
bind dswk_wake_status dswk_chk chk_u (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_wake_pin_in(rc_wake_pin_in), .rc_wake_pin_out(rc_wake_pin_out),
    .rc_wake_pin_oe(rc_wake_pin_oe), .rc_wake_output_signal(rc_wake_output_signal),
    .wake_done(wake_done), .deep_wake_reset_req(deep_wake_reset_req),
    .wake_request(wake_request), .irq(irq));
